/* common/ticu_pkg.sv */
// timer input capture unit: register indices, field positions, reset values, carrier types
// assumes a 32-bit AHB-Lite slave port; each byte register sits in the low byte of a word
package ticu_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_PORT_A = 8'h00;
  localparam logic [7:0] IDX_OC1_MASK = 8'h0c;
  localparam logic [7:0] IDX_OC1_DATA = 8'h0d;
  localparam logic [7:0] IDX_CAP1_HI = 8'h10;
  localparam logic [7:0] IDX_CAP1_LO = 8'h11;
  localparam logic [7:0] IDX_CAP2_HI = 8'h12;
  localparam logic [7:0] IDX_CAP2_LO = 8'h13;
  localparam logic [7:0] IDX_CAP3_HI = 8'h14;
  localparam logic [7:0] IDX_CAP3_LO = 8'h15;
  localparam logic [7:0] IDX_SHARED_HI = 8'h1e;
  localparam logic [7:0] IDX_SHARED_LO = 8'h1f;
  localparam logic [7:0] IDX_EDGE_CTRL = 8'h21;
  localparam logic [7:0] IDX_MASK_ONE = 8'h22;
  localparam logic [7:0] IDX_FLAGS_ONE = 8'h23;
  localparam logic [7:0] IDX_PA_CTRL = 8'h26;
  // edge control field lsb per channel (index 0..3 = capture one..four)
  localparam int EDGE_LSB_CH1 = 4;
  localparam int EDGE_LSB_CH2 = 2;
  localparam int EDGE_LSB_CH3 = 0;
  localparam int EDGE_LSB_CH4 = 6;
  // timer flag and mask bit positions
  localparam int FLG_CAP1 = 2;
  localparam int FLG_CAP2 = 1;
  localparam int FLG_CAP3 = 0;
  localparam int FLG_CAP4 = 3;
  localparam int FLG_OVF = 7;
  localparam logic [7:0] FLG_IMPL = 8'h8f;
  // pulse accumulator control bits used here
  localparam int PAC_DIR7 = 7;
  localparam int PAC_DIR3 = 3;
  localparam int PAC_SEL4 = 2;
  localparam logic [7:0] PAC_IMPL = 8'h8c;
  // port a structure
  localparam logic [7:0] PA_OUT_ALWAYS = 8'h70;
  localparam logic [7:0] PA_OC1_BITS = 8'hf8;
  localparam logic [7:0] PA_DIR_BITS = 8'h88;
  // reset values, count limit and step, high address zero
  localparam logic [15:0] SHARED_RESET = 16'hffff;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_STEP = 16'h0001;
  localparam logic [21:0] ADDR_HIGH_ZERO = 22'h000000;

  typedef enum logic [1:0] {
    TICU_EDGE_OFF = 2'b00,
    TICU_EDGE_RISE = 2'b01,
    TICU_EDGE_FALL = 2'b10,
    TICU_EDGE_ANY = 2'b11
  } ticu_edge_type;

  // ahb-lite address phase group
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } ticu_ahb_req_type;

  // compare side group: en/lvl index 0..3 = compare two..five
  typedef struct packed {
    logic [3:0] en;
    logic [3:0] lvl;
    logic oc1_evt;
  } ticu_oc_type;

  // all reset state of the unit
  typedef struct packed {
    logic [15:0] count;
    logic [7:0] edge_ctrl;
    logic [7:0] pa_ctrl;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [7:0] oc1m;
    logic [7:0] oc1d;
    logic [15:0] shared;
    logic [3:0] smp;
    logic [3:0] prev;
    logic [3:0] hold;
    logic [3:0] pend;
    logic [3:0][15:0] pend_val;
    logic [7:0] pa_lvl;
    logic [7:0] pa_oe;
    logic irq;
    logic ready;
    logic dph_wr;
    logic [7:0] dph_idx;
    logic [31:0] rdata;
  } ticu_state_type;
endpackage

/* hw/ticu_top.sv */
// timer input capture unit with port a pin control and an ahb-lite register slave
// assumes synchronous pin inputs, one clock, and a single-master zero-wait bus
module ticu_top (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // ahb-lite slave
  input wire ticu_pkg::ticu_ahb_req_type ahb_req_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // port a pins and compare side
  input wire logic [7:0] pa_i,
  input wire ticu_pkg::ticu_oc_type oc_i,
  output logic [7:0] pa_o,
  output logic [7:0] pa_oe_o,
  // interrupt
  output logic irq_o
);
  localparam ticu_pkg::ticu_state_type ST_RESET = '{
    count: ticu_pkg::COUNT_RESET,
    shared: ticu_pkg::SHARED_RESET,
    pa_oe: ticu_pkg::PA_OUT_ALWAYS,
    ready: 1'b1,
    default: '0
  };

  ticu_pkg::ticu_state_type st_q, st_d;
  logic [2:0][15:0] cap_q, cap_d;
  logic [3:0] cap_we;
  logic [3:0][15:0] cap_v;
  logic [3:0] edge_now;
  logic [7:0] drive;
  logic acc, addr_ok, sel4;
  logic [7:0] idx;

  // edge field lsb for channel c
  function automatic int edge_lsb(input int c);
    unique case (c)
      0: edge_lsb = ticu_pkg::EDGE_LSB_CH1;
      1: edge_lsb = ticu_pkg::EDGE_LSB_CH2;
      2: edge_lsb = ticu_pkg::EDGE_LSB_CH3;
      default: edge_lsb = ticu_pkg::EDGE_LSB_CH4;
    endcase
  endfunction

  // flag bit for channel c
  function automatic int flag_bit(input int c);
    unique case (c)
      0: flag_bit = ticu_pkg::FLG_CAP1;
      1: flag_bit = ticu_pkg::FLG_CAP2;
      2: flag_bit = ticu_pkg::FLG_CAP3;
      default: flag_bit = ticu_pkg::FLG_CAP4;
    endcase
  endfunction

  // high byte index of channel c
  function automatic logic [7:0] hi_idx(input int c);
    unique case (c)
      0: hi_idx = ticu_pkg::IDX_CAP1_HI;
      1: hi_idx = ticu_pkg::IDX_CAP2_HI;
      2: hi_idx = ticu_pkg::IDX_CAP3_HI;
      default: hi_idx = ticu_pkg::IDX_SHARED_HI;
    endcase
  endfunction

  // edge match for one channel
  function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic cur);
    ticu_pkg::ticu_edge_type m;
    m = ticu_pkg::ticu_edge_type'(mode);
    unique case (m)
      ticu_pkg::TICU_EDGE_OFF: edge_hit = 1'b0;
      ticu_pkg::TICU_EDGE_RISE: edge_hit = cur & ~prev;
      ticu_pkg::TICU_EDGE_FALL: edge_hit = ~cur & prev;
      ticu_pkg::TICU_EDGE_ANY: edge_hit = cur ^ prev;
    endcase
  endfunction

  // address phase decode
  assign acc = ahb_req_i.hsel & ahb_req_i.htrans[1] & ahb_req_i.hready;
  assign addr_ok = ahb_req_i.haddr[31:10] == ticu_pkg::ADDR_HIGH_ZERO;
  assign idx = ahb_req_i.haddr[9:2];
  assign sel4 = st_q.pa_ctrl[ticu_pkg::PAC_SEL4];

  // port bits held by a compare function
  assign drive = (st_q.oc1m & ticu_pkg::PA_OC1_BITS)
    | {1'b0, oc_i.en[0], oc_i.en[1], oc_i.en[2], oc_i.en[3] & ~sel4, 3'b000};

  // edge detection per channel; capture four needs its select bit
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      edge_now[c] = edge_hit(st_q.edge_ctrl[edge_lsb(c) +: 2], st_q.prev[c], st_q.smp[c]);
    end
    edge_now[3] = edge_now[3] & sel4;
  end

  // next state
  always_comb begin
    logic [7:0] set_f;
    logic [7:0] clr_f;
    logic [7:0] rd;
    logic [7:0] wd;
    set_f = '0;
    clr_f = '0;
    rd = '0;
    wd = hwdata_i[7:0];
    st_d = st_q;
    cap_we = '0;
    cap_v = '0;

    // free-running count with overflow
    st_d.count = st_q.count + ticu_pkg::COUNT_STEP;
    if (st_q.count == ticu_pkg::COUNT_MAX) begin
      set_f[ticu_pkg::FLG_OVF] = 1'b1;
    end

    // pin sampling; bit three follows the driven level when it is an output
    st_d.prev = st_q.smp;
    st_d.smp = {st_q.pa_oe[3] ? st_q.pa_lvl[3] : pa_i[3], pa_i[0], pa_i[1], pa_i[2]};

    // per channel capture, hold and pending transfer
    for (int c = 0; c < 4; c++) begin
      if (st_q.hold[c]) begin
        if (edge_now[c]) begin
          st_d.pend[c] = 1'b1;
          st_d.pend_val[c] = st_q.count;
        end
      end else if (st_q.pend[c]) begin
        cap_we[c] = 1'b1;
        cap_v[c] = st_q.pend_val[c];
        st_d.pend[c] = edge_now[c];
        st_d.pend_val[c] = st_q.count;
      end else if (edge_now[c]) begin
        cap_we[c] = 1'b1;
        cap_v[c] = st_q.count;
      end
      if (cap_we[c]) begin
        set_f[flag_bit(c)] = 1'b1;
      end
    end
    cap_d = cap_q;
    for (int c = 0; c < 3; c++) begin
      if (cap_we[c]) begin
        cap_d[c] = cap_v[c];
      end
    end

    // data phase writes
    if (st_q.dph_wr) begin
      unique case (st_q.dph_idx)
        ticu_pkg::IDX_PORT_A: begin
          st_d.pa_lvl[7:3] = (wd[7:3] & ~drive[7:3]) | (st_q.pa_lvl[7:3] & drive[7:3]);
        end
        ticu_pkg::IDX_OC1_MASK: st_d.oc1m = wd & ticu_pkg::PA_OC1_BITS;
        ticu_pkg::IDX_OC1_DATA: st_d.oc1d = wd & ticu_pkg::PA_OC1_BITS;
        ticu_pkg::IDX_SHARED_HI: begin
          if (!sel4) begin
            st_d.shared[15:8] = wd;
          end
        end
        ticu_pkg::IDX_SHARED_LO: begin
          if (!sel4) begin
            st_d.shared[7:0] = wd;
          end
        end
        ticu_pkg::IDX_EDGE_CTRL: st_d.edge_ctrl = wd;
        ticu_pkg::IDX_MASK_ONE: st_d.mask = wd & ticu_pkg::FLG_IMPL;
        ticu_pkg::IDX_FLAGS_ONE: clr_f = wd & ticu_pkg::FLG_IMPL;
        ticu_pkg::IDX_PA_CTRL: st_d.pa_ctrl = wd & ticu_pkg::PAC_IMPL;
        default: ;
      endcase
    end
    if (cap_we[3]) begin
      st_d.shared = cap_v[3];
    end

    // compare levels onto their pins, then compare one on its selected bits
    for (int b = 3; b < 7; b++) begin
      if (drive[b] && !st_q.oc1m[b]) begin
        st_d.pa_lvl[b] = oc_i.lvl[6 - b];
      end
    end
    if (oc_i.oc1_evt) begin
      st_d.pa_lvl = (st_q.oc1d & st_q.oc1m) | (st_d.pa_lvl & ~st_q.oc1m);
    end
    st_d.pa_lvl[2:0] = 3'b000;

    // pin directions: 6:4 always out, 7 and 3 by direction bit or compare drive
    st_d.pa_oe = ticu_pkg::PA_OUT_ALWAYS | (drive & ticu_pkg::PA_DIR_BITS)
      | (st_d.pa_ctrl & ticu_pkg::PA_DIR_BITS);

    // flags: a set in the same cycle as a clear wins
    st_d.flags = (st_q.flags & ~clr_f) | set_f;
    st_d.irq = |(st_d.flags & st_d.mask);

    // address phase: read data, high-byte hold, data phase capture
    st_d.hold = '0;
    for (int c = 0; c < 4; c++) begin
      if (acc && addr_ok && !ahb_req_i.hwrite && idx == hi_idx(c)) begin
        st_d.hold[c] = 1'b1;
      end
    end
    if (acc && addr_ok) begin
      unique case (idx)
        ticu_pkg::IDX_PORT_A: begin
          rd = (st_q.pa_lvl & st_q.pa_oe) | (pa_i & ~st_q.pa_oe);
        end
        ticu_pkg::IDX_OC1_MASK: rd = st_q.oc1m;
        ticu_pkg::IDX_OC1_DATA: rd = st_q.oc1d;
        ticu_pkg::IDX_CAP1_HI: rd = cap_q[0][15:8];
        ticu_pkg::IDX_CAP1_LO: rd = cap_q[0][7:0];
        ticu_pkg::IDX_CAP2_HI: rd = cap_q[1][15:8];
        ticu_pkg::IDX_CAP2_LO: rd = cap_q[1][7:0];
        ticu_pkg::IDX_CAP3_HI: rd = cap_q[2][15:8];
        ticu_pkg::IDX_CAP3_LO: rd = cap_q[2][7:0];
        ticu_pkg::IDX_SHARED_HI: rd = st_q.shared[15:8];
        ticu_pkg::IDX_SHARED_LO: rd = st_q.shared[7:0];
        ticu_pkg::IDX_EDGE_CTRL: rd = st_q.edge_ctrl;
        ticu_pkg::IDX_MASK_ONE: rd = st_q.mask;
        ticu_pkg::IDX_FLAGS_ONE: rd = st_q.flags;
        ticu_pkg::IDX_PA_CTRL: rd = st_q.pa_ctrl;
        default: rd = '0;
      endcase
    end
    st_d.rdata = (acc && !ahb_req_i.hwrite) ? {24'h000000, rd} : '0;
    st_d.dph_wr = acc & addr_ok & ahb_req_i.hwrite;
    st_d.dph_idx = idx;
    st_d.ready = 1'b1;
  end

  // reset state register; edge fields and selects clear here
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= ST_RESET;
    end else if (ce_i) begin
      st_q <= st_d;
    end
  end

  // capture values keep their contents through reset
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      cap_q <= cap_d;
    end
  end

  // outputs straight from flip-flops; hresp_o tied low
  assign hrdata_o = st_q.rdata;
  assign hreadyout_o = st_q.ready;
  assign hresp_o = 1'b0;
  assign pa_o = st_q.pa_lvl;
  assign pa_oe_o = st_q.pa_oe;
  assign irq_o = st_q.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  AST_EDGE_OFF: assert property (
    ce_i && st_q.edge_ctrl[5:4] == 2'b00 && !st_q.pend[0] && !st_q.flags[2]
    |=> !st_q.flags[2]) else $error("disabled channel one set its flag");
  AST_CAP_VALUE: assert property (
    ce_i && edge_now[0] && !st_q.hold[0] && !st_q.pend[0]
    |=> cap_q[0] == $past(st_q.count)) else $error("capture one latched wrong count");
  AST_HOLD_BLOCKS: assert property (
    ce_i && st_q.hold[1] |=> cap_q[1] == $past(cap_q[1])) else $error("capture during hold");
  AST_PEND_KEPT: assert property (
    (ce_i && st_q.hold[0] && edge_now[0]) ##1 (ce_i && !st_q.hold[0])
    |=> cap_q[0] == $past(st_q.count, 2)) else $error("postponed capture lost");
  AST_SHARED_WR_IGNORED: assert property (
    ce_i && sel4 && st_q.dph_wr && st_q.dph_idx == ticu_pkg::IDX_SHARED_LO && !cap_we[3]
    |=> st_q.shared == $past(st_q.shared)) else $error("write changed capture four");
  AST_LOW_PINS_READ: assert property (
    ce_i && acc && addr_ok && !ahb_req_i.hwrite && idx == ticu_pkg::IDX_PORT_A
    |=> hrdata_o[2:0] == $past(pa_i[2:0])) else $error("port low bits misread");
  AST_OC_PROTECT: assert property (
    ce_i && st_q.dph_wr && st_q.dph_idx == ticu_pkg::IDX_PORT_A && oc_i.en[0]
    && !st_q.oc1m[6] && !oc_i.oc1_evt |=> pa_o[6] == $past(oc_i.lvl[0]))
    else $error("port write overrode compare pin");
  AST_COUNT_WRAP: assert property (
    ce_i && st_q.count == ticu_pkg::COUNT_MAX
    |=> st_q.count == ticu_pkg::COUNT_RESET && st_q.flags[ticu_pkg::FLG_OVF])
    else $error("count wrap or overflow flag wrong");
  AST_IC4_GATED: assert property (
    ce_i && !sel4 && !st_q.pend[3] |=> !st_q.pend[3] && !$rose(st_q.flags[3]))
    else $error("capture four acted while deselected");
  AST_IRQ: assert property (
    irq_o == |(st_q.flags & st_q.mask)) else $error("interrupt does not match flags");

  COV_CAP1: cover property (ce_i && cap_we[0]);
  COV_PEND: cover property (ce_i && st_q.hold[0] && edge_now[0]);
  COV_CAP4: cover property (ce_i && cap_we[3]);
  COV_WRAP: cover property (ce_i && st_q.count == ticu_pkg::COUNT_MAX);
endmodule

/* tb/ticu_pins_model.sv */
// pin-side partner: drives the port a pin levels that the bench requests
// assumes the bench changes req_i right after a rising edge of clk_i
module ticu_pins_model (
  // clock
  input wire logic clk_i,
  // requested levels and pins
  input wire logic [7:0] req_i,
  output logic [7:0] pa_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins start low and move one edge after a request, synchronous to the clock
  initial pa_o = 8'h00;
  always @(posedge clk_i) begin
    pa_o <= req_i;
  end
endmodule

/* tb/tb.sv */
// bench for the timer input capture unit: ahb-lite register tasks and pin scenarios
// assumes a zero-wait slave and a free count that steps on every clock
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic irq;
  logic [7:0] pins = 8'h00;
  logic [7:0] pa_i;
  logic [7:0] pa_o;
  logic [7:0] pa_oe;
  logic [7:0] rv;
  logic [7:0] hi;
  logic [7:0] lo;
  logic [15:0] v0;
  logic [15:0] v1;
  ticu_pkg::ticu_oc_type oc = '0;
  ticu_pkg::ticu_ahb_req_type req;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0;
  int t1;

  // clock, cycle count and bus request assembly
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  assign req = '{hsel, haddr, htrans, hwrite, 3'h2, hready};

  ticu_top uut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .ahb_req_i(req),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .pa_i(pa_i), .oc_i(oc), .pa_o(pa_o), .pa_oe_o(pa_oe), .irq_o(irq));
  ticu_pins_model pins_m (.clk_i(clk_i), .req_i(pins), .pa_o(pa_i));

  // compare and count
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one single transfer: address phase, then data phase, each held until hready
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata[7:0];
    chk("hresp", 16'(hresp), 16'h0);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    bus(1'b1, idx, val, rv);
  endtask

  task automatic rdc(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, rv);
    chk(nm, 16'(rv), 16'(exp));
  endtask

  // high byte first, then low byte
  task automatic rd16(input logic [7:0] idx, output logic [15:0] v);
    bus(1'b0, idx, 8'h00, hi);
    bus(1'b0, idx + 8'h01, 8'h00, lo);
    v = {hi, lo};
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog at 90000 cycles, about 24300 above the overflow wait that ends near cycle 65700
  initial begin
    repeat (90000) @(posedge clk_i);
    mismatches++;
    print_verdict();
  end

  // main sequence
  initial begin
    tick(6);
    rstn_i <= 1'b1;
    tick(1);
    rdc("edge_rst", ticu_pkg::IDX_EDGE_CTRL, 8'h00);
    rdc("pulse_accumulator_control_rst", ticu_pkg::IDX_PA_CTRL, 8'h00);
    rdc("shared_hi_rst", ticu_pkg::IDX_SHARED_HI, 8'hff);
    rdc("shared_lo_rst", ticu_pkg::IDX_SHARED_LO, 8'hff);
    rdc("unmapped", 8'h3f, 8'h00);
    chk("oe_rst", 16'(pa_oe), 16'h0070);
    $display("test reset done");
    // every edge mode on capture one, rising then falling
    wr(ticu_pkg::IDX_MASK_ONE, 8'h04);
    for (int m = 0; m < 4; m++) begin
      wr(ticu_pkg::IDX_EDGE_CTRL, 8'(m << 4));
      wr(ticu_pkg::IDX_FLAGS_ONE, 8'hff);
      pins <= 8'h04;
      tick(6);
      rdc("rise_flag", ticu_pkg::IDX_FLAGS_ONE, {5'h0, m[0], 2'h0});
      chk("irq", 16'(irq), 16'(m[0]));
      wr(ticu_pkg::IDX_FLAGS_ONE, 8'hff);
      pins <= 8'h00;
      tick(6);
      rdc("fall_flag", ticu_pkg::IDX_FLAGS_ONE, {5'h0, m[1], 2'h0});
    end
    $display("test edge modes done");
    // three channels on the same edge latch the same count
    wr(ticu_pkg::IDX_EDGE_CTRL, 8'h15);
    wr(ticu_pkg::IDX_FLAGS_ONE, 8'hff);
    pins <= 8'h07;
    tick(6);
    rdc("flags_three", ticu_pkg::IDX_FLAGS_ONE, 8'h07);
    rd16(ticu_pkg::IDX_CAP1_HI, v0);
    rd16(ticu_pkg::IDX_CAP2_HI, v1);
    chk("same_two", v1, v0);
    rd16(ticu_pkg::IDX_CAP3_HI, v1);
    chk("same_three", v1, v0);
    wr(ticu_pkg::IDX_CAP1_HI, 8'h5a);
    tick(1);
    rd16(ticu_pkg::IDX_CAP1_HI, v1);
    chk("cap_ro", v1, v0);
    $display("test same count done");
    // edges five cycles apart give captures five counts apart
    wr(ticu_pkg::IDX_EDGE_CTRL, 8'h3c);
    pins <= 8'h03;
    tick(5);
    pins <= 8'h01;
    tick(6);
    rd16(ticu_pkg::IDX_CAP1_HI, v0);
    rd16(ticu_pkg::IDX_CAP2_HI, v1);
    chk("gap", v1 - v0, 16'h0005);
    // an edge detected in the cycle after a high byte read lands one cycle late
    pins <= 8'h05;
    t0 = cyc;
    tick(8);
    rd16(ticu_pkg::IDX_CAP1_HI, v0);
    pins <= 8'h01;
    t1 = cyc;
    tick(1);
    rd16(ticu_pkg::IDX_CAP1_HI, v1);
    chk("hold_coherent", v1, v0);
    tick(4);
    rd16(ticu_pkg::IDX_CAP1_HI, v1);
    chk("delayed_cap", v1 - v0, 16'(t1 - t0));
    $display("test capture timing done");
    // shared register: compare five by default, capture four when selected
    wr(ticu_pkg::IDX_SHARED_HI, 8'h12);
    tick(1);
    rdc("shared_rw", ticu_pkg::IDX_SHARED_HI, 8'h12);
    wr(ticu_pkg::IDX_PA_CTRL, 8'h04);
    wr(ticu_pkg::IDX_SHARED_HI, 8'h34);
    tick(1);
    rdc("shared_locked", ticu_pkg::IDX_SHARED_HI, 8'h12);
    wr(ticu_pkg::IDX_EDGE_CTRL, 8'h40);
    wr(ticu_pkg::IDX_FLAGS_ONE, 8'hff);
    pins <= 8'h0f;
    tick(6);
    rdc("cap4_flag", ticu_pkg::IDX_FLAGS_ONE, 8'h08);
    // bit three as output: a written rising edge is captured
    wr(ticu_pkg::IDX_PORT_A, 8'h00);
    wr(ticu_pkg::IDX_PA_CTRL, 8'h0c);
    tick(4);
    wr(ticu_pkg::IDX_FLAGS_ONE, 8'hff);
    wr(ticu_pkg::IDX_PORT_A, 8'h08);
    tick(6);
    rdc("written_edge", ticu_pkg::IDX_FLAGS_ONE, 8'h08);
    chk("oe3", 16'(pa_oe[3]), 16'h0001);
    $display("test capture four done");
    // pin levels, compare ownership and compare one
    pins <= 8'h05;
    tick(3);
    bus(1'b0, ticu_pkg::IDX_PORT_A, 8'h00, rv);
    chk("pin_lvl", 16'(rv[2:0]), 16'h0005);
    oc <= '{en: 4'b0001, lvl: 4'b0001, oc1_evt: 1'b0};
    wr(ticu_pkg::IDX_PORT_A, 8'h30);
    tick(2);
    chk("oc_owns_pin", 16'(pa_o[6:4]), 16'h0007);
    chk("oe_six_four", 16'(pa_oe[6:4]), 16'h0007);
    wr(ticu_pkg::IDX_PA_CTRL, 8'h8c);
    wr(ticu_pkg::IDX_OC1_MASK, 8'ha0);
    wr(ticu_pkg::IDX_OC1_DATA, 8'h80);
    tick(1);
    oc.oc1_evt <= 1'b1;
    tick(1);
    oc.oc1_evt <= 1'b0;
    tick(2);
    chk("oc1_pins", 16'({pa_o[7], pa_o[5]}), 16'h0002);
    chk("pa7_oe", 16'(pa_oe[7]), 16'h0001);
    $display("test port a done");
    // overflow flag appears only once the count has wrapped from all ones
    while (cyc < 65400) @(posedge clk_i);
    bus(1'b0, ticu_pkg::IDX_FLAGS_ONE, 8'h00, rv);
    chk("ovf_early", 16'(rv[7]), 16'h0000);
    while (cyc < 65700) @(posedge clk_i);
    bus(1'b0, ticu_pkg::IDX_FLAGS_ONE, 8'h00, rv);
    chk("ovf_wrap", 16'(rv[7]), 16'h0001);
    $display("test overflow done");
    print_verdict();
  end
endmodule
